// >>> hdl/pscc_power_ctrl.sv
// pscc_power_ctrl: power state sequencing, power-up reset of the registered
// outputs, test preload, and programming and read-back of the configuration.
// assumes every input is an asynchronous pin and is synchronised here; the
// device clock pin is sampled and its rising edge used as a load enable.
// pin pulses under one ref_clk period may be missed.
`timescale 1ns/1ps
`default_nettype none
module pscc_power_ctrl (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          powerDownRequestPin,
    input  wire logic                          devClk,
    input  wire logic                          outEnableN,
    input  wire logic [pscc_pkg::NUM_REGS-1:0] arrayNext,
    input  wire logic                          preloadEn,
    input  wire logic [pscc_pkg::NUM_REGS-1:0] preloadData,
    input  wire logic                          progMode,
    input  wire logic                          progWrite,
    input  wire logic                          progSecure,
    input  wire logic [pscc_pkg::ADDR_W-1:0]   progAddr,
    input  wire logic [pscc_pkg::BYTE_W-1:0]   progData,
    input  wire logic                          readReq,
    output logic      [pscc_pkg::NUM_REGS-1:0] regPinOut,
    output logic      [pscc_pkg::NUM_REGS-1:0] regPinOeN,
    output logic                               outputsValid,
    output logic                               standby,
    output logic                               porDone,
    output logic      [pscc_pkg::BYTE_W-1:0]   readData,
    output logic                               readValid,
    output logic                               readRefused,
    output logic                               securedOut,
    output logic      [pscc_pkg::CSUM_W-1:0]   checksum
);
    import pscc_pkg::*;

    // one packed record: two sync stages, an edge stage,
    // power states, output image and store strobes
    typedef struct packed {
        pscc_pins_t              syncA;
        pscc_pins_t              syncB;
        pscc_pins_t              prevB;
        pscc_pwr_t               state;
        logic [CNT_W-1:0]        cnt;
        logic [NUM_REGS-1:0]     regQ;
        logic [NUM_REGS-1:0]     pinOut;
        logic [NUM_REGS-1:0]     pinOeN;
        logic                    outValid;
        logic                    standby;
        logic                    porDone;
        logic [BYTE_W-1:0]       rdData;
        logic                    rdValid;
        logic                    rdRefused;
        logic                    secured;
        logic [CSUM_W-1:0]       csum;
        logic                    erase;
        logic                    wrEn;
        logic [ADDR_W-1:0]       wrAddr;
        logic [BYTE_W-1:0]       wrData;
        logic                    secureSet;
    } pscc_ctrl_t;

    // reset image: registers low, pins high, outputs off
    localparam pscc_ctrl_t CTRL_RESET = '{
        syncA:     '0,
        syncB:     '0,
        prevB:     '0,
        state:     ST_POR,
        cnt:       CNT_ZERO,
        regQ:      REG_RESET,
        pinOut:    ~REG_RESET,
        pinOeN:    '1,
        outValid:  1'b0,
        standby:   1'b0,
        porDone:   1'b0,
        rdData:    BYTE_ZERO,
        rdValid:   1'b0,
        rdRefused: 1'b0,
        secured:   1'b0,
        csum:      CSUM_ZERO,
        erase:     1'b0,
        wrEn:      1'b0,
        wrAddr:    '0,
        wrData:    BYTE_ZERO,
        secureSet: 1'b0
    };

    // every output is a field of c_ff
    pscc_ctrl_t c_ff;
    pscc_ctrl_t nxt_c;
    pscc_pins_t pinsIn;
    pscc_cfg_if cfgBus ();

    // store reads are combinational; writes land one edge
    // after the strobe, status copies one edge later
    pscc_cfg_store u_store (
        .ref_clk (ref_clk),
        .rst     (rst),
        .cfg     (cfgBus)
    );

    // gather pins into one bundle for the two-stage synchroniser
    // data and clock share one delay, so loads see aligned data
    always_comb begin
        pinsIn.powerDownRequestPin = powerDownRequestPin;
        pinsIn.devClk              = devClk;
        pinsIn.outEnableN          = outEnableN;
        pinsIn.progMode            = progMode;
        pinsIn.progWrite           = progWrite;
        pinsIn.progSecure          = progSecure;
        pinsIn.readReq             = readReq;
        pinsIn.preloadEn           = preloadEn;
        pinsIn.arrayNext           = arrayNext;
        pinsIn.preloadData         = preloadData;
        pinsIn.progAddr            = progAddr;
        pinsIn.progData            = progData;
    end

    // store strobes come straight from registers
    assign cfgBus.erase     = c_ff.erase;
    assign cfgBus.wrEn      = c_ff.wrEn;
    assign cfgBus.wrAddr    = c_ff.wrAddr;
    assign cfgBus.wrData    = c_ff.wrData;
    assign cfgBus.secureSet = c_ff.secureSet;
    // read address is live; its data is taken on a read edge
    assign cfgBus.rdAddr    = c_ff.syncB.progAddr;

    // whole next state of the controller
    always_comb begin
        logic clkRise;
        logic progRise;
        logic wrRise;
        logic secRise;
        logic rdRise;
        logic pdHigh;
        logic [NUM_REGS-1:0] loadVal;
        clkRise  = 1'b0;
        progRise = 1'b0;
        wrRise   = 1'b0;
        secRise  = 1'b0;
        rdRise   = 1'b0;
        pdHigh   = 1'b0;
        loadVal  = REG_RESET;

        nxt_c = c_ff;
        // pin stages shift every edge, in every state
        nxt_c.syncA = pinsIn;
        nxt_c.syncB = c_ff.syncA;
        nxt_c.prevB = c_ff.syncB;

        // one strobe per pin edge, from stage two and its copy
        clkRise  = c_ff.syncB.devClk && !c_ff.prevB.devClk;
        progRise = c_ff.syncB.progMode && !c_ff.prevB.progMode;
        wrRise   = c_ff.syncB.progWrite && !c_ff.prevB.progWrite;
        secRise  = c_ff.syncB.progSecure && !c_ff.prevB.progSecure;
        rdRise   = c_ff.syncB.readReq && !c_ff.prevB.readReq;
        // the power-down pin only reaches the state machine
        pdHigh   = c_ff.syncB.powerDownRequestPin;

        // preload overrides the array feedback path for test
        // illegal states can be forced this way
        if (c_ff.syncB.preloadEn) begin
            loadVal = c_ff.syncB.preloadData;
        end else begin
            loadVal = c_ff.syncB.arrayNext;
        end

        // strobes and the read pulse last one cycle
        nxt_c.erase     = 1'b0;
        nxt_c.wrEn      = 1'b0;
        nxt_c.secureSet = 1'b0;
        nxt_c.rdValid   = 1'b0;

        // one-hot states; an unknown code restarts power-up
        case (c_ff.state)
            ST_POR: begin
                // clock edges ignored until the reset interval expires
                // enable pin followed, so reset level shows
                nxt_c.regQ    = REG_RESET;
                nxt_c.pinOut  = ~REG_RESET;
                nxt_c.pinOeN  = {NUM_REGS{c_ff.syncB.outEnableN}};
                nxt_c.cnt     = c_ff.cnt + 1'b1;
                // ends on the last count, inside the limit
                if (c_ff.cnt == POR_LAST) begin
                    nxt_c.cnt      = CNT_ZERO;
                    nxt_c.porDone  = 1'b1;
                    nxt_c.outValid = 1'b1;
                    nxt_c.state    = ST_ACTIVE;
                end
            end

            ST_ACTIVE: begin
                if (pdHigh) begin
                    // stop sampling at once; held state stays put
                    // a clock edge arriving with the request is dropped
                    nxt_c.standby  = 1'b1;
                    nxt_c.outValid = 1'b0;
                    nxt_c.state    = ST_STANDBY;
                end else begin
                    // enable follows its pin only while active or in power-up reset
                    nxt_c.pinOeN = {NUM_REGS{c_ff.syncB.outEnableN}};
                    if (clkRise) begin
                        nxt_c.regQ   = loadVal;
                        nxt_c.pinOut = ~loadVal;
                    end
                end
            end

            ST_STANDBY: begin
                // inputs and clock are don't-care; registers retained
                // enable image frozen as well
                nxt_c.regQ = c_ff.regQ;
                // release goes through the synchroniser too
                if (!pdHigh) begin
                    nxt_c.standby = 1'b0;
                    nxt_c.cnt     = CNT_ZERO;
                    nxt_c.state   = ST_WAKE;
                end
            end

            ST_WAKE: begin
                // outputs reappear one cycle after wake starts, held value intact
                // a new request here skips the valid flag
                nxt_c.cnt = c_ff.cnt + 1'b1;
                if (pdHigh) begin
                    nxt_c.standby = 1'b1;
                    nxt_c.state   = ST_STANDBY;
                end else if (c_ff.cnt == WAKE_LAST) begin
                    nxt_c.cnt      = CNT_ZERO;
                    nxt_c.pinOut   = ~c_ff.regQ;
                    nxt_c.outValid = 1'b1;
                    nxt_c.state    = ST_ACTIVE;
                end
            end

            default: begin
                nxt_c.state = ST_POR;
                nxt_c.cnt   = CNT_ZERO;
            end
        endcase

        // programming: entering the mode always erases first
        if (progRise) begin
            nxt_c.erase = 1'b1;
        end else if (c_ff.syncB.progMode && wrRise) begin
            nxt_c.wrEn   = 1'b1;
            nxt_c.wrAddr = c_ff.syncB.progAddr;
            nxt_c.wrData = c_ff.syncB.progData;
        end

        // a set arriving with the erase survives it: the store
        // applies it after wiping, so the set wins
        if (c_ff.syncB.progMode && secRise) begin
            nxt_c.secureSet = 1'b1;
        end

        // read-back: signature always open, array bits closed once secured
        // a refused read still pulses readValid
        if (rdRise) begin
            nxt_c.rdValid = 1'b1;
            // the signature range is never guarded
            if (c_ff.syncB.progAddr >= SIG_BASE) begin
                nxt_c.rdData    = cfgBus.rdData;
                nxt_c.rdRefused = 1'b0;
            end else if (cfgBus.secured) begin
                nxt_c.rdData    = BYTE_ZERO;
                nxt_c.rdRefused = 1'b1;
            end else begin
                nxt_c.rdData    = cfgBus.rdData;
                nxt_c.rdRefused = 1'b0;
            end
        end

        // status copies trail the store by one edge
        nxt_c.secured = cfgBus.secured;
        nxt_c.csum    = cfgBus.checksum;
    end

    // the reset branch loads a constant image only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            c_ff <= CTRL_RESET;
        end else begin
            c_ff <= nxt_c;
        end
    end

    // every output taken straight from the state register
    // nothing combinational reaches a pin
    assign regPinOut    = c_ff.pinOut;
    assign regPinOeN    = c_ff.pinOeN;
    assign outputsValid = c_ff.outValid;
    assign standby      = c_ff.standby;
    assign porDone      = c_ff.porDone;
    assign readData     = c_ff.rdData;
    assign readValid    = c_ff.rdValid;
    assign readRefused  = c_ff.rdRefused;
    assign securedOut   = c_ff.secured;
    assign checksum     = c_ff.csum;
endmodule
`default_nettype wire

// >>> hdl/pscc_pkg.sv
// pscc_pkg: constants, pin bundle and state types for the power state and
// configuration controller.
// assumes a single 10 MHz ref_clk; all timing counts derive from its period.
package pscc_pkg;

    localparam int CLK_PERIOD_NS = 100;

    // power-up reset duration, a longest time, so rounded down
    localparam int POR_TIME_NS   = 10000;
    localparam int POR_CYC_RAW   = POR_TIME_NS / CLK_PERIOD_NS;
    localparam int POR_CYCLES    = (POR_CYC_RAW < 1) ? 1 : POR_CYC_RAW;

    // wake to output valid window: least rounds up, longest rounds down
    localparam int WAKE_MIN_NS   = 5;
    localparam int WAKE_MAX_NS   = 45;
    localparam int WAKE_MIN_RAW  = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_MAX_RAW  = WAKE_MAX_NS / CLK_PERIOD_NS;
    localparam int WAKE_MIN_CYC  = (WAKE_MIN_RAW < 1) ? 1 : WAKE_MIN_RAW;
    localparam int WAKE_MAX_CYC  = (WAKE_MAX_RAW < 1) ? 1 : WAKE_MAX_RAW;
    localparam int WAKE_CYCLES   = (WAKE_MIN_CYC > WAKE_MAX_CYC) ? WAKE_MAX_CYC
                                                                  : WAKE_MIN_CYC;

    localparam int CNT_W         = 8;
    localparam logic [CNT_W-1:0] POR_LAST  = CNT_W'(POR_CYCLES - 1);
    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;

    // registered outputs and configuration store geometry
    localparam int NUM_REGS      = 8;
    localparam int BYTE_W        = 8;
    localparam int CFG_WORDS     = 16;
    localparam int SIG_BITS      = 64;
    localparam int SIG_WORDS     = SIG_BITS / BYTE_W;
    localparam int ADDR_W        = 5;
    localparam int CSUM_W        = 16;
    localparam logic [ADDR_W-1:0] SIG_BASE  = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 5'h17;

    localparam logic [NUM_REGS-1:0] REG_RESET = 8'h00;
    localparam logic [BYTE_W-1:0]   BYTE_ZERO = 8'h00;
    localparam logic [CSUM_W-1:0]   CSUM_ZERO = 16'h0000;

    typedef enum logic [3:0] {
        ST_POR     = 4'h1,
        ST_ACTIVE  = 4'h2,
        ST_STANDBY = 4'h4,
        ST_WAKE    = 4'h8
    } pscc_pwr_t;

    // every pin that enters from outside, sampled as one bundle
    typedef struct packed {
        logic                powerDownRequestPin;
        logic                devClk;
        logic                outEnableN;
        logic                progMode;
        logic                progWrite;
        logic                progSecure;
        logic                readReq;
        logic                preloadEn;
        logic [NUM_REGS-1:0] arrayNext;
        logic [NUM_REGS-1:0] preloadData;
        logic [ADDR_W-1:0]   progAddr;
        logic [BYTE_W-1:0]   progData;
    } pscc_pins_t;

endpackage

// >>> hdl/pscc_cfg_if.sv
// pscc_cfg_if: carrier between the controller and the configuration store.
// assumes both ends run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface pscc_cfg_if;
    import pscc_pkg::*;
    logic                  erase;
    logic                  wrEn;
    logic [ADDR_W-1:0]     wrAddr;
    logic [BYTE_W-1:0]     wrData;
    logic                  secureSet;
    logic [ADDR_W-1:0]     rdAddr;
    logic [BYTE_W-1:0]     rdData;
    logic                  secured;
    logic [CSUM_W-1:0]     checksum;

    modport ctrl  (output erase, wrEn, wrAddr, wrData, secureSet, rdAddr,
                   input  rdData, secured, checksum);
    modport store (input  erase, wrEn, wrAddr, wrData, secureSet, rdAddr,
                   output rdData, secured, checksum);
endinterface
`default_nettype wire

// >>> hdl/pscc_cfg_store.sv
// pscc_cfg_store: configuration words, signature words, security cell and
// checksum over the configuration and signature words.
// assumes the controller issues erase before writes of a programming cycle.
`timescale 1ns/1ps
`default_nettype none
module pscc_cfg_store (
    input  wire logic ref_clk,
    input  wire logic rst,
    pscc_cfg_if.store cfg
);
    import pscc_pkg::*;

    typedef struct packed {
        logic [CFG_WORDS-1:0][BYTE_W-1:0] words;
        logic [SIG_WORDS-1:0][BYTE_W-1:0] sig;
        logic                             secure;
    } pscc_store_t;

    pscc_store_t st_ff;
    pscc_store_t nxt_st;
    logic [CSUM_W-1:0] sum;

    // erase wipes everything, security included, before any write lands
    always_comb begin
        nxt_st = st_ff;
        if (cfg.erase) begin
            nxt_st = '0;
        end else begin
            if (cfg.wrEn && cfg.wrAddr < SIG_BASE) begin
                nxt_st.words[cfg.wrAddr[3:0]] = cfg.wrData;
            end else if (cfg.wrEn && cfg.wrAddr <= ADDR_LAST) begin
                nxt_st.sig[cfg.wrAddr[2:0]] = cfg.wrData;
            end
        end
        // a set meeting the erase lands after it
        if (cfg.secureSet) begin
            nxt_st.secure = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // checksum spans configuration and signature bytes alike
    always_comb begin
        sum = CSUM_ZERO;
        for (int i = 0; i < CFG_WORDS; i++) begin
            sum = sum + {BYTE_ZERO, st_ff.words[i]};
        end
        for (int j = 0; j < SIG_WORDS; j++) begin
            sum = sum + {BYTE_ZERO, st_ff.sig[j]};
        end
    end

    // raw read; the controller decides whether it may leave the device
    always_comb begin
        if (cfg.rdAddr < SIG_BASE) begin
            cfg.rdData = st_ff.words[cfg.rdAddr[3:0]];
        end else if (cfg.rdAddr <= ADDR_LAST) begin
            cfg.rdData = st_ff.sig[cfg.rdAddr[2:0]];
        end else begin
            cfg.rdData = BYTE_ZERO;
        end
    end

    assign cfg.secured  = st_ff.secure;
    assign cfg.checksum = sum;
endmodule
`default_nettype wire

// >>> testbench/pscc_sys_model.sv
// pscc_sys_model: system glue on the far side, making the device clock pin.
// assumes ref_clk at 10 MHz; devClk runs at a quarter of it when enabled.
`timescale 1ns/1ps
`default_nettype none
module pscc_sys_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic clkRun,
    input  wire logic outputsValid,
    input  wire logic powerDownRequestPin,
    output logic      devClk
);
    logic [1:0] phase;

    // clock static during power-up and standby, restarted only once outputs
    // are valid again, so the wake wait is always honoured
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase  <= 2'h0;
            devClk <= 1'b0;
        end else if (clkRun && outputsValid && !powerDownRequestPin) begin
            phase  <= #10 phase + 2'h1;
            devClk <= #10 phase[1]; // two cycles high, two low
        end else begin
            phase  <= #10 2'h0;
            devClk <= #10 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/pscc_power_ctrl_assertions.sv
// pscc_power_ctrl_assertions: port-level checks of the power controller.
// assumes binding to pscc_power_ctrl and the 2-flop pin synchronisers.
`timescale 1ns/1ps
`default_nettype none
module pscc_power_ctrl_assertions (
    input wire logic                          ref_clk,
    input wire logic                          rst,
    input wire logic                          powerDownRequestPin,
    input wire logic                          progMode,
    input wire logic [pscc_pkg::ADDR_W-1:0]   progAddr,
    input wire logic [pscc_pkg::NUM_REGS-1:0] regPinOut,
    input wire logic [pscc_pkg::NUM_REGS-1:0] regPinOeN,
    input wire logic                          outputsValid,
    input wire logic                          standby,
    input wire logic                          porDone,
    input wire logic [pscc_pkg::BYTE_W-1:0]   readData,
    input wire logic                          readValid,
    input wire logic                          readRefused,
    input wire logic                          securedOut,
    input wire logic [pscc_pkg::CSUM_W-1:0]   checksum
);
    import pscc_pkg::*;
    logic [7:0] porCnt;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // cycles spent waiting for power-up reset to end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) porCnt <= 8'h00;
        else if (!porDone) porCnt <= porCnt + 8'h01;
    end

    sequence s_pinHigh; (porDone && powerDownRequestPin) [*4]; endsequence
    sequence s_pinLow; (porDone && !powerDownRequestPin) [*4]; endsequence

    property p_enterStandby; s_pinHigh |-> standby && !outputsValid; endproperty
    a_enterStandby: assert property (p_enterStandby) else $error("no standby");
    property p_leaveStandby; s_pinLow |-> !standby; endproperty
    a_leaveStandby: assert property (p_leaveStandby) else $error("stuck in standby");
    property p_wakeValid;
        $fell(standby) && !powerDownRequestPin && !$past(powerDownRequestPin)
            |-> !outputsValid ##1 outputsValid;
    endproperty
    a_wakeValid: assert property (p_wakeValid) else $error("wake output timing");
    property p_porHigh; !porDone |-> regPinOut == 8'hFF; endproperty
    a_porHigh: assert property (p_porHigh) else $error("outputs not high in reset");
    property p_porTime; $rose(porDone) |-> porCnt >= 8'h61 && porCnt <= 8'h64; endproperty
    a_porTime: assert property (p_porTime) else $error("reset interval wrong");
    property p_porLimit; porCnt <= 8'h64; endproperty
    a_porLimit: assert property (p_porLimit) else $error("reset too long");
    property p_porOnce; porDone |=> porDone; endproperty
    a_porOnce: assert property (p_porOnce) else $error("reset done dropped");
    property p_retain; standby |=> $stable(regPinOut) && $stable(regPinOeN); endproperty
    a_retain: assert property (p_retain) else $error("state lost in standby");
    property p_refused; readValid && readRefused |-> readData == 8'h00; endproperty
    a_refused: assert property (p_refused) else $error("refused read leaks");
    property p_secure;
        readValid && $past(securedOut) && $past(progAddr, 3) < 5'h10 |-> readRefused;
    endproperty
    a_secure: assert property (p_secure) else $error("secured read allowed");
    property p_sigRead; readValid && $past(progAddr, 3) >= 5'h10 |-> !readRefused; endproperty
    a_sigRead: assert property (p_sigRead) else $error("signature refused");
    property p_erase; $rose(progMode) |-> ##[4:7] checksum == 16'h0000 && !securedOut;
    endproperty
    a_erase: assert property (p_erase) else $error("no erase on programming");
    property p_secClear; $fell(securedOut) |-> progMode; endproperty
    a_secClear: assert property (p_secClear) else $error("security cleared");
endmodule

bind pscc_power_ctrl pscc_power_ctrl_assertions i_pscc_power_ctrl_assertions (
    .ref_clk, .rst, .powerDownRequestPin, .progMode, .progAddr, .regPinOut, .regPinOeN,
    .outputsValid, .standby, .porDone, .readData, .readValid, .readRefused, .securedOut,
    .checksum);
`default_nettype wire

// >>> testbench/pscc_power_ctrl_tb.sv
// pscc_power_ctrl_tb: self-checking bench for the power state controller.
// assumes the bench drives every pin 10 ns after a rising ref_clk edge.
`timescale 1ns/1ps
`default_nettype none
module pscc_power_ctrl_tb;
    import pscc_pkg::*;
    typedef struct packed { logic [7:0] data; logic refused; } pscc_rd_t;
    logic ref_clk, rst, powerDownRequestPin, devClk, outEnableN, preloadEn, progMode;
    logic progWrite, progSecure, readReq, clkRun, secState;
    logic [7:0] arrayNext, preloadData, progData, v, nv, readData, regPinOut, regPinOeN;
    logic [4:0] progAddr;
    logic outputsValid, standby, porDone, readValid, readRefused, securedOut;
    logic [15:0] checksum, expSum;
    logic [7:0] mem [0:23];
    pscc_rd_t expQ[$];
    pscc_rd_t got;
    int err_count, check_count, cycles, seed, i;

    pscc_power_ctrl i_pscc_power_ctrl (.ref_clk, .rst, .powerDownRequestPin, .devClk,
        .outEnableN, .arrayNext, .preloadEn, .preloadData, .progMode, .progWrite,
        .progSecure, .progAddr, .progData, .readReq, .regPinOut, .regPinOeN, .outputsValid,
        .standby, .porDone, .readData, .readValid, .readRefused, .securedOut, .checksum);
    pscc_sys_model i_pscc_sys_model (.ref_clk, .rst, .clkRun, .outputsValid,
        .powerDownRequestPin, .devClk);

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // all drives land 10 ns past an edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask

    // address and data settle three cycles ahead of the strobe
    task automatic prog_write(input logic [4:0] a, input logic [7:0] d);
        progAddr = a;
        progData = d;
        step(3);
        progWrite = 1'b1;
        step(2);
        progWrite = 1'b0;
        step(2);
        expSum = expSum - 16'(mem[a]) + 16'(d);
        mem[a] = d;
    endtask

    task automatic prog_read(input logic [4:0] a);
        pscc_rd_t e;
        e.refused = secState && a < 5'h10;
        e.data = (e.refused || a > 5'h17) ? 8'h00 : mem[a];
        expQ.push_back(e);
        progAddr = a;
        step(3);
        readReq = 1'b1;
        step(2);
        readReq = 1'b0;
        step(3);
    endtask

    // read results against the oldest note; a pulse with no note is stray
    always @(negedge ref_clk) begin
        if (readValid === 1'b1) begin
            if (expQ.size() == 0) check(16'hFFFF, 16'h0000);
            else begin
                got = expQ.pop_front();
                check(16'({readData, readRefused}), 16'(got));
            end
        end
    end

    // hang guard, well above the roughly 470 cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        {powerDownRequestPin, clkRun, preloadEn, progMode, progWrite, progSecure} = '0;
        {readReq, secState, arrayNext, preloadData, progData, progAddr} = '0;
        outEnableN = 1'b1;
        rst = 1'b1;
        seed = 47730;
        expSum = 16'h0000;
        for (i = 0; i < 24; i++) mem[i] = 8'h00;
        step(8);
        check(16'(regPinOut), 16'h00FF);
        rst = 1'b0;
        outEnableN = 1'b0;
        for (i = 0; i < 200 && porDone !== 1'b1; i++) step(1);
        check(16'(porDone), 16'h0001);
        check(16'(regPinOut), 16'h00FF);
        check(16'(regPinOeN), 16'h0000);
        // array loads and preloads alternate, clock from the model
        clkRun = 1'b1;
        for (i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            preloadEn = i[0];
            preloadData = v;
            arrayNext = i[0] ? 8'($random(seed)) : v;
            nv = ~v;
            step(12);
            check(16'(regPinOut), 16'(nv));
        end
        // standby: array, preload and enable pins disturbed, state must hold
        powerDownRequestPin = 1'b1;
        step(5);
        check(16'(standby), 16'h0001);
        check(16'(outputsValid), 16'h0000);
        arrayNext = 8'($random(seed));
        preloadEn = 1'b0;
        outEnableN = 1'b1;
        step(10);
        check(16'(regPinOut), 16'(nv));
        check(16'(regPinOeN), 16'h0000);
        powerDownRequestPin = 1'b0;
        step(1);
        outEnableN = 1'b0;
        step(5);
        check(16'(standby), 16'h0000);
        check(16'(outputsValid), 16'h0001);
        check(16'(regPinOut), 16'(nv));
        nv = ~arrayNext;
        step(12);
        check(16'(regPinOut), 16'(nv));
        // programming: erase, fill, read, secure, re-enter to erase again
        progMode = 1'b1;
        step(8);
        check(checksum, 16'h0000);
        for (i = 0; i < 24; i++) prog_write(5'(i), 8'($random(seed)));
        step(3);
        check(checksum, expSum);
        prog_read(5'h03);
        prog_read(5'h12);
        prog_read(5'h1F);
        prog_write(5'h10, mem[16] + 8'h01);
        step(3);
        check(checksum, expSum);
        progSecure = 1'b1;
        step(2);
        progSecure = 1'b0;
        secState = 1'b1;
        step(4);
        check(16'(securedOut), 16'h0001);
        prog_read(5'h02);
        prog_read(5'h15);
        progMode = 1'b0;
        step(3);
        progMode = 1'b1;
        step(8);
        for (i = 0; i < 24; i++) mem[i] = 8'h00;
        secState = 1'b0;
        check(16'(securedOut), 16'h0000);
        check(checksum, 16'h0000);
        prog_read(5'h02);
        step(4);
        check(16'(expQ.size()), 16'h0000);
        finish_test();
    end
endmodule
`default_nettype wire
